// ===== hdl/aqef_map.vh
// Register map, field positions and reset values for the queue event flags.
`ifndef AQEF_MAP_VH
`define AQEF_MAP_VH

// ****************************************************************
// Register byte offsets
// ****************************************************************
`define AQEF_ADDR_W          4
`define AQEF_OFF_STATUS      4'h0
`define AQEF_OFF_IRQ_EN      4'h4
`define AQEF_OFF_EVT_STATUS  4'h8
`define AQEF_OFF_EVT_MASK    4'hc

// ****************************************************************
// Register select codes
// ****************************************************************
`define AQEF_SEL_STATUS      3'h0
`define AQEF_SEL_IRQ_EN      3'h1
`define AQEF_SEL_EVT_STATUS  3'h2
`define AQEF_SEL_EVT_MASK    3'h3
`define AQEF_SEL_NONE        3'h4

// ****************************************************************
// Flag bit positions, shared by every register
// ****************************************************************
`define AQEF_NFLAGS          4
`define AQEF_BIT_Q1_COMPLETE 0
`define AQEF_BIT_Q1_PAUSE    1
`define AQEF_BIT_Q2_COMPLETE 2
`define AQEF_BIT_Q2_PAUSE    3

// ****************************************************************
// Reset values
// ****************************************************************
`define AQEF_RST_FLAGS       4'h0
`define AQEF_RST_IRQ_EN      4'h0
`define AQEF_RST_EVT_STATUS  4'h0
`define AQEF_RST_EVT_MASK    4'h0

// ****************************************************************
// Bus responses
// ****************************************************************
`define AQEF_RESP_OKAY       2'h0
`define AQEF_RESP_SLVERR     2'h2

`endif

// ===== hdl/aqef_top.v
// Queue completion and pause flags with interrupt requests and bus slave.
`timescale 1ns/1ps
`include "aqef_map.vh"

module aqef_top (
  input  wire        aclk,               // System clock, 50 MHz
  input  wire        aresetn,            // Synchronous reset, active low
  input  wire [3:0]  s_axi_awaddr,       // Write address
  input  wire        s_axi_awvalid,      // Write address valid
  output reg         s_axi_awready,      // Write address ready
  input  wire [31:0] s_axi_wdata,        // Write data
  input  wire [3:0]  s_axi_wstrb,        // Write byte strobes
  input  wire        s_axi_wvalid,       // Write data valid
  output reg         s_axi_wready,       // Write data ready
  output reg  [1:0]  s_axi_bresp,        // Write response
  output reg         s_axi_bvalid,       // Write response valid
  input  wire        s_axi_bready,       // Write response ready
  input  wire [3:0]  s_axi_araddr,       // Read address
  input  wire        s_axi_arvalid,      // Read address valid
  output reg         s_axi_arready,      // Read address ready
  output reg  [31:0] s_axi_rdata,        // Read data
  output reg  [1:0]  s_axi_rresp,        // Read response
  output reg         s_axi_rvalid,       // Read data valid
  input  wire        s_axi_rready,       // Read data ready
  input  wire        result_wr,          // Converter writes a result
  input  wire        result_queue,       // Queue of that result, 0 q1, 1 q2
  input  wire        result_last,        // Word was the last of its queue
  input  wire        result_pause,       // Word had its pause bit set
  output reg         q1_complete_irq,    // Queue 1 completion request
  output reg         q1_pause_irq,       // Queue 1 pause request
  output reg         q2_complete_irq,    // Queue 2 completion request
  output reg         q2_pause_irq,       // Queue 2 pause request
  output reg         evt_irq             // Summary event interrupt
);

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function [2:0] reg_sel;
    input [3:0] addr;
    begin
      case (addr)
        `AQEF_OFF_STATUS:     reg_sel = `AQEF_SEL_STATUS;
        `AQEF_OFF_IRQ_EN:     reg_sel = `AQEF_SEL_IRQ_EN;
        `AQEF_OFF_EVT_STATUS: reg_sel = `AQEF_SEL_EVT_STATUS;
        `AQEF_OFF_EVT_MASK:   reg_sel = `AQEF_SEL_EVT_MASK;
        default:              reg_sel = `AQEF_SEL_NONE;
      endcase
    end
  endfunction

  // ****************************************************************
  // State
  // ****************************************************************
  reg  [3:0]  adc_queue_status_reg;
  reg  [3:0]  adc_queue_status_next;
  reg  [3:0]  clear_arm_reg;
  reg  [3:0]  clear_arm_next;
  reg  [3:0]  irq_en_reg;
  reg  [3:0]  evt_status_reg;
  reg  [3:0]  evt_status_next;
  reg  [3:0]  evt_mask_reg;
  reg  [3:0]  aw_addr_reg;
  reg         aw_full_reg;
  reg  [31:0] w_data_reg;
  reg  [3:0]  w_strb_reg;
  reg         w_full_reg;
  reg  [3:0]  event_vec;
  reg  [3:0]  irq_vec;
  reg  [31:0] rd_word;

  wire [2:0]  wr_sel;
  wire [2:0]  rd_sel;
  wire        wr_fire;
  wire        rd_fire;
  wire        st_wr;
  wire        st_rd;
  integer     i;

  // ****************************************************************
  // Converter events
  // ****************************************************************
  always @* begin
    event_vec = 4'h0;
    event_vec[`AQEF_BIT_Q1_COMPLETE] =
      result_wr & ~result_queue & result_last;
    event_vec[`AQEF_BIT_Q1_PAUSE] =
      result_wr & ~result_queue & result_pause;
    event_vec[`AQEF_BIT_Q2_COMPLETE] =
      result_wr & result_queue & result_last;
    event_vec[`AQEF_BIT_Q2_PAUSE] =
      result_wr & result_queue & result_pause;
  end

  // ****************************************************************
  // Bus handshakes
  // ****************************************************************
  // A write is carried out once both address and data are held and the
  // previous response has gone, so only one write is ever in flight.
  assign wr_fire = aw_full_reg & w_full_reg & ~s_axi_bvalid;
  assign wr_sel  = reg_sel(aw_addr_reg);
  assign rd_fire = s_axi_arvalid & s_axi_arready;
  assign rd_sel  = reg_sel(s_axi_araddr);
  assign st_wr   = wr_fire & (wr_sel == `AQEF_SEL_STATUS) & w_strb_reg[0];
  assign st_rd   = rd_fire & (rd_sel == `AQEF_SEL_STATUS);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg   <= 1'b0;
      aw_addr_reg   <= 4'h0;
      s_axi_awready <= 1'b0;
      w_full_reg    <= 1'b0;
      w_data_reg    <= 32'h0;
      w_strb_reg    <= 4'h0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= `AQEF_RESP_OKAY;
    end else begin
      s_axi_awready <= ~aw_full_reg & ~(s_axi_awvalid & s_axi_awready);
      s_axi_wready  <= ~w_full_reg & ~(s_axi_wvalid & s_axi_wready);
      if (s_axi_awvalid & s_axi_awready) begin
        aw_full_reg <= 1'b1;
        aw_addr_reg <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        w_full_reg <= 1'b1;
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        if (wr_sel == `AQEF_SEL_NONE)
          s_axi_bresp <= `AQEF_RESP_SLVERR;
        else
          s_axi_bresp <= `AQEF_RESP_OKAY;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Read path
  // ****************************************************************
  always @* begin
    rd_word = 32'h0;
    case (rd_sel)
      `AQEF_SEL_STATUS:     rd_word[3:0] = adc_queue_status_reg;
      `AQEF_SEL_IRQ_EN:     rd_word[3:0] = irq_en_reg;
      `AQEF_SEL_EVT_STATUS: rd_word[3:0] = evt_status_reg;
      `AQEF_SEL_EVT_MASK:   rd_word[3:0] = evt_mask_reg;
      default:              rd_word = 32'h0;
    endcase
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= `AQEF_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~rd_fire;
      if (rd_fire) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_word;
        if (rd_sel == `AQEF_SEL_NONE)
          s_axi_rresp <= `AQEF_RESP_SLVERR;
        else
          s_axi_rresp <= `AQEF_RESP_OKAY;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Queue flags and clear protection
  // ****************************************************************
  // A bit is armed by a status read that saw it set; a new event on that bit disarms
  // it, so a zero written afterwards cannot wipe an event it never saw.
  always @* begin
    adc_queue_status_next = adc_queue_status_reg;
    clear_arm_next        = clear_arm_reg;
    if (st_wr)
      clear_arm_next = 4'h0;
    if (st_rd)
      clear_arm_next = adc_queue_status_reg;
    for (i = 0; i < `AQEF_NFLAGS; i = i + 1) begin
      if (st_wr & ~w_data_reg[i] & clear_arm_reg[i])
        adc_queue_status_next[i] = 1'b0;
      if (event_vec[i]) begin
        adc_queue_status_next[i] = 1'b1;
        clear_arm_next[i]        = 1'b0;
      end
    end
  end

  // ****************************************************************
  // System event status, write one to clear
  // ****************************************************************
  always @* begin
    evt_status_next = evt_status_reg;
    if (wr_fire & (wr_sel == `AQEF_SEL_EVT_STATUS) & w_strb_reg[0])
      evt_status_next = evt_status_reg & ~w_data_reg[3:0];
    evt_status_next = evt_status_next | event_vec;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      adc_queue_status_reg <= `AQEF_RST_FLAGS;
      clear_arm_reg        <= 4'h0;
      irq_en_reg           <= `AQEF_RST_IRQ_EN;
      evt_status_reg       <= `AQEF_RST_EVT_STATUS;
      evt_mask_reg         <= `AQEF_RST_EVT_MASK;
    end else begin
      adc_queue_status_reg <= adc_queue_status_next;
      clear_arm_reg        <= clear_arm_next;
      evt_status_reg       <= evt_status_next;
      if (wr_fire & w_strb_reg[0]) begin
        if (wr_sel == `AQEF_SEL_IRQ_EN)
          irq_en_reg <= w_data_reg[3:0];
        if (wr_sel == `AQEF_SEL_EVT_MASK)
          evt_mask_reg <= w_data_reg[3:0];
      end
    end
  end

  // ****************************************************************
  // Interrupt outputs
  // ****************************************************************
  // Each line follows its own flag; nothing here orders them, so the
  // system controller sees four independent levels.
  always @* begin
    irq_vec = adc_queue_status_reg & irq_en_reg;
  end

  always @(posedge aclk) begin
    if (!aresetn) begin
      q1_complete_irq <= 1'b0;
      q1_pause_irq    <= 1'b0;
      q2_complete_irq <= 1'b0;
      q2_pause_irq    <= 1'b0;
      evt_irq         <= 1'b0;
    end else begin
      q1_complete_irq <= irq_vec[`AQEF_BIT_Q1_COMPLETE];
      q1_pause_irq    <= irq_vec[`AQEF_BIT_Q1_PAUSE];
      q2_complete_irq <= irq_vec[`AQEF_BIT_Q2_COMPLETE];
      q2_pause_irq    <= irq_vec[`AQEF_BIT_Q2_PAUSE];
      evt_irq         <= |(evt_status_next & evt_mask_reg);
    end
  end

endmodule

// ===== dv/aqef_sva.sv
// Port-level concurrent checks for the queue event flag block.
`timescale 1ns/1ps
module aqef_sva (
  input wire logic        aclk, aresetn, result_wr, result_queue,
  input wire logic        result_last, result_pause, s_axi_bvalid,
  input wire logic        s_axi_bready, s_axi_awvalid, s_axi_awready,
  input wire logic        s_axi_wvalid, s_axi_wready, s_axi_arvalid,
  input wire logic        s_axi_arready, s_axi_rvalid, s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        q1_complete_irq, q1_pause_irq,
  input wire logic        q2_complete_irq, q2_pause_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire [3:0] irq = {q2_pause_irq, q2_complete_irq, q1_pause_irq,
                    q1_complete_irq};
  // A register write lands one cycle before its lines may move.
  sequence wr_done;
    $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2);
  endsequence
  sequence ev(bit q, bit c);
    $past(result_wr && result_queue == q &&
          (c ? result_last : result_pause), 2);
  endsequence
  q1c_rise_a: assert property ($rose(q1_complete_irq) |->
    ev(1'b0, 1'b1) or wr_done) else $error("q1 complete rose unprompted");
  q1p_rise_a: assert property ($rose(q1_pause_irq) |->
    ev(1'b0, 1'b0) or wr_done) else $error("q1 pause rose unprompted");
  q2c_rise_a: assert property ($rose(q2_complete_irq) |->
    ev(1'b1, 1'b1) or wr_done) else $error("q2 complete rose unprompted");
  q2p_rise_a: assert property ($rose(q2_pause_irq) |->
    ev(1'b1, 1'b0) or wr_done) else $error("q2 pause rose unprompted");
  irq_fall_a: assert property ((|($past(irq) & ~irq)) |->
    wr_done) else $error("request dropped without a write");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid) else $error("write response withdrawn early");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  bresp_time_a: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write response late");
  rresp_time_a: assert property (s_axi_arvalid && s_axi_arready |->
    ##[1:2] s_axi_rvalid) else $error("read response late");
endmodule
bind aqef_top aqef_sva aqef_sva_inst (.*);

// ===== dv/aqef_irq_ctrl_model.sv
// Interrupt controller model that records each request line on its own.
`timescale 1ns/1ps
module aqef_irq_ctrl_model (
  input wire logic       aclk,    // System clock
  input wire logic       aresetn, // Synchronous reset, active low
  input wire logic [3:0] irq_req, // One request line per source
  output logic     [3:0] pending  // Sources seen active since reset
);
  // Each line owns a bit of pending, so no source is ever held behind another.
  always @(posedge aclk) begin
    pending <= aresetn ? (pending | irq_req) : 4'h0;
  end
endmodule

// ===== dv/tb_adc_queue_event_flags.sv
// Register-level self-checking bench for the queue event flag block.
`timescale 1ns/1ps
`include "aqef_map.vh"
module tb_adc_queue_event_flags;
  logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0;
  logic s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
  logic result_wr = 0, result_queue = 0, result_last = 0, result_pause = 0;
  logic [3:0] s_axi_awaddr = 0, s_axi_araddr = 0, s_axi_wstrb = 4'hf;
  logic [31:0] s_axi_wdata = 0, rd;
  logic [1:0] rs;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire q1_complete_irq, q1_pause_irq, q2_complete_irq, q2_pause_irq, evt_irq;
  wire [3:0] irq = {q2_pause_irq, q2_complete_irq, q1_pause_irq,
                    q1_complete_irq};
  wire [3:0] pending;
  integer fail_count = 0, checked = 0, cycles = 0, i;
  always #10 aclk = ~aclk;
  aqef_top aqef_top_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .result_wr, .result_queue, .result_last, .result_pause, .q1_complete_irq,
    .q1_pause_irq, .q2_complete_irq, .q2_pause_irq, .evt_irq);
  aqef_irq_ctrl_model aqef_irq_ctrl_model_inst (.aclk, .aresetn,
    .irq_req(irq), .pending);
  task close_out;
    begin
      $display("checks %0d mismatches %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
    end
  endtask
  // The run should end within 2000 cycles; a hang is cut off at 6000.
  always @(posedge aclk) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fail_count = fail_count + 1;
      close_out;
    end
  end
  task automatic chk(input string what, input [31:0] exp, input [31:0] got);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("Error %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // Handshakes are judged at the negative edge, where inputs only change
  // on the rising edge, so the decision never races the design's update.
  task automatic wr(input [3:0] a, input [31:0] d);
    logic ah, wh, bh;
    begin
      @(posedge aclk);
      s_axi_awaddr <= a; s_axi_wdata <= d;
      s_axi_awvalid <= 1; s_axi_wvalid <= 1; s_axi_bready <= 1;
      bh = 0;
      while (!bh) begin
        @(negedge aclk);
        ah = s_axi_awvalid & s_axi_awready;
        wh = s_axi_wvalid & s_axi_wready;
        bh = s_axi_bvalid;
        rs = s_axi_bresp;
        @(posedge aclk);
        if (ah) s_axi_awvalid <= 0;
        if (wh) s_axi_wvalid <= 0;
      end
      s_axi_bready <= 0;
    end
  endtask
  task automatic rdreg(input [3:0] a);
    logic ah, dh;
    begin
      @(posedge aclk);
      s_axi_araddr <= a; s_axi_arvalid <= 1; s_axi_rready <= 1;
      dh = 0;
      while (!dh) begin
        @(negedge aclk);
        ah = s_axi_arvalid & s_axi_arready;
        dh = s_axi_rvalid;
        rd = s_axi_rdata; rs = s_axi_rresp;
        @(posedge aclk);
        if (ah) s_axi_arvalid <= 0;
      end
      s_axi_rready <= 0;
    end
  endtask
  task automatic pulse(input logic q, input logic l, input logic p);
    begin
      @(posedge aclk);
      result_wr <= 1; result_queue <= q; result_last <= l; result_pause <= p;
      @(posedge aclk);
      result_wr <= 0;
      @(posedge aclk);
      @(negedge aclk);
    end
  endtask
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1;
    for (i = 0; i < 4; i = i + 1) begin
      rdreg(i * 4);
      chk("reset value", 32'h0, rd);
    end
    for (i = 0; i < 4; i = i + 1) begin
      pulse(i[1], !i[0], i[0]);
      rdreg(`AQEF_OFF_STATUS);
      chk("polled status", (2 << i) - 1, rd);
      chk("masked lines", 32'h0, {28'h0, irq});
    end
    wr(`AQEF_OFF_STATUS, 32'hf);
    chk("write resp", `AQEF_RESP_OKAY, {30'h0, rs});
    wr(`AQEF_OFF_STATUS, 32'h0);
    rdreg(`AQEF_OFF_STATUS);
    chk("status kept", 32'hf, rd);
    for (i = 0; i < 4; i = i + 1) begin
      wr(`AQEF_OFF_IRQ_EN, 32'h1 << i);
      @(negedge aclk);
      chk("one line", 32'h1 << i, {28'h0, irq});
    end
    wr(`AQEF_OFF_IRQ_EN, 32'hf);
    rdreg(`AQEF_OFF_STATUS);
    wr(`AQEF_OFF_STATUS, 32'h0);
    rdreg(`AQEF_OFF_STATUS);
    chk("cleared", 32'h0, rd);
    @(negedge aclk);
    chk("withdrawn", 32'h0, {28'h0, irq});
    pulse(1'b0, 1'b1, 1'b1);
    rdreg(`AQEF_OFF_STATUS);
    pulse(1'b0, 1'b1, 1'b0);
    wr(`AQEF_OFF_STATUS, 32'h0);
    rdreg(`AQEF_OFF_STATUS);
    chk("late event kept", 32'h1, rd);
    @(negedge aclk);
    chk("late event line", 32'h1, {28'h0, irq});
    wr(`AQEF_OFF_EVT_MASK, 32'h1);
    @(negedge aclk);
    chk("event irq on", 32'h1, {31'h0, evt_irq});
    wr(`AQEF_OFF_EVT_STATUS, 32'hf);
    rdreg(`AQEF_OFF_EVT_STATUS);
    chk("event status", 32'h0, rd);
    chk("event irq off", 32'h0, {31'h0, evt_irq});
    rdreg(4'h2);
    chk("unmapped resp", `AQEF_RESP_SLVERR, {30'h0, rs});
    chk("controller saw", 32'hf, {28'h0, pending});
    close_out;
  end
endmodule
